// File: core/psr_pkg.sv
package psr_pkg;
  // ==========================================
  // Fixed-point formats
  localparam int VAL_W     = 16;
  localparam int ACC_W     = 40;
  localparam int FRAC_W    = 12;
  localparam int GAIN_FRAC = 7;
  // ==========================================
  // Register offsets
  localparam logic [15:0] TARGET_WORD_OFS = 16'h0006;
  localparam logic [15:0] SRC_CTRL_OFS    = 16'h000F;
  localparam int          SRC_TARGET_BIT  = 1;
  // ==========================================
  // Parameter codes and defaults
  localparam logic [3:0]  AIN_FN_FEEDBACK = 4'h8;
  localparam logic [3:0]  AIN_FN_TARGET   = 4'h9;
  localparam logic [2:0]  MODE_MAX        = 3'h4;
  localparam logic [15:0] GAIN_MAX        = 16'h09C4;
  localparam logic [15:0] GAIN_DEFAULT    = 16'h0064;
  localparam logic [15:0] ITIME_MAX       = 16'h0E10;
  localparam logic [15:0] ITIME_DEFAULT   = 16'h000A;
  localparam logic [15:0] PCT_MAX         = 16'h03E8;
  localparam logic [15:0] DTIME_MAX       = 16'h03E8;
  localparam logic [15:0] LAG_MAX         = 16'h03E8;
  localparam logic [15:0] FULL_SCALE      = 16'h4000;
  // ==========================================
  // Timing
  localparam int CLK_HZ      = 125_000_000;
  localparam int TICK_US     = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICK_CNT_W  = 17;
  // ==========================================
  // Types
  typedef enum logic [2:0] {
    MODE_OFF, MODE_DIRECT_DEV, MODE_DIRECT_FB, MODE_ADD_DEV, MODE_ADD_FB
  } psr_mode_t;

  typedef struct packed {
    logic [2:0]  mode;
    logic [15:0] p_gain;
    logic [15:0] i_time;
    logic [15:0] i_clamp;
    logic [15:0] d_time;
    logic [15:0] out_limit;
    logic [15:0] bias;
    logic [15:0] lag_time;
    logic        sign_invert;
    logic [15:0] out_gain;
    logic        reverse_en;
    logic        param_tgt_en;
    logic [15:0] param_tgt;
    logic [3:0]  ain1_fn;
    logic [3:0]  ain2_fn;
    logic        diff_fb_en;
  } psr_cfg_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } psr_bus_req_t;
endpackage

// File: core/psr_scale.sv
`timescale 1ns/1ps
// ==========================================
// Signed value times unsigned gain in hundredths, saturated
module psr_scale (
  input  wire logic signed [psr_pkg::ACC_W-1:0] value,
  input  wire logic        [15:0]               gain,
  output logic signed      [psr_pkg::ACC_W-1:0] result
);
  localparam int PW = psr_pkg::ACC_W + 17;
  localparam logic signed [PW-1:0] HUNDRED = 57'sd100;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] q;
  localparam logic signed [PW-1:0] LIM = (57'sd1 <<< (psr_pkg::ACC_W - 2));

  always_comb begin
    prod = PW'(value) * $signed({1'b0, gain});
    q = prod / HUNDRED;
    // Saturate so a large gain cannot wrap the accumulator sign
    if (q > LIM) begin
      result = LIM[psr_pkg::ACC_W-1:0];
    end else if (q < -LIM) begin
      result = -(LIM[psr_pkg::ACC_W-1:0]);
    end else begin
      result = q[psr_pkg::ACC_W-1:0];
    end
  end
endmodule

// File: core/psr_regulator.sv
`timescale 1ns/1ps
// Function
// R01: Mode 0 off, modes 1-4 enabled
// R02: Mode 1 output is regulator, derivative on deviation
// R03: Mode 2 output is regulator, derivative on feedback
// R04: Modes 3,4 add frequency command to output
// R05: Proportional gain 0.00-25.00, default 1.00
// R06: Integral time 0-360 s, zero disables
// R07: Integral term clamped to percent of maximum
// R08: Derivative time 0-10 s, zero disables
// R09: Output clamped to upper limit percent
// R10: Signed bias percent added to output
// R11: First-order lag filter on output
// R12: Sign invert setting flips output direction
// R13: Output multiplied by output gain
// R14: Target priority: analog, parameter, fieldbus
// R15: Analog 1 function 9 gives target
// R16: Both analogs function 9 raise fault
// R17: Analog 1 function 8 gives feedback
// R18: Multiple feedback sources raise separate fault
// R19: Differential feedback uses two input difference
// R20: Negative output zeroed unless reverse allowed; code zeroes it in modes 1,2 only, not when the command is added
// R21: Whole chain recomputed once per tick
module psr_regulator (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // Configuration parameters
  input  wire psr_pkg::psr_cfg_t     CFG,
  input  wire logic [15:0]           MAX_OUTPUT_FREQUENCY,
  // Analog inputs, frequency command
  input  wire logic [15:0]           ANALOG_IN1,
  input  wire logic [15:0]           ANALOG_IN2,
  input  wire logic signed [15:0]    FREQ_COMMAND,
  // Register port
  input  wire psr_pkg::psr_bus_req_t BUS_REQ,
  output logic [15:0]                BUS_RDATA,
  output logic                       BUS_RVALID,
  // Results
  output logic signed [15:0]         OUTPUT_FREQUENCY,
  output logic                       REVERSE_RUN,
  output logic signed [15:0]         DEVIATION_MONITOR,
  output logic signed [15:0]         FEEDBACK_MONITOR,
  output logic                       DUP_TARGET_FAULT,
  output logic                       DUP_FEEDBACK_FAULT
);
  localparam int AW = psr_pkg::ACC_W;
  localparam int FW = psr_pkg::FRAC_W;
  localparam int US_PER_DECI    = 100_000;
  localparam int TICKS_PER_DECI = US_PER_DECI / psr_pkg::TICK_US;

  // ==========================================
  // Fieldbus registers
  logic [15:0] target_value_word_reg;
  logic [15:0] regulator_source_control_reg;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      target_value_word_reg        <= 16'h0000;
      regulator_source_control_reg <= 16'h0000;
    end else if (BUS_REQ.we) begin
      if (BUS_REQ.addr == psr_pkg::TARGET_WORD_OFS) begin
        target_value_word_reg <= BUS_REQ.wdata;
      end
      if (BUS_REQ.addr == psr_pkg::SRC_CTRL_OFS) begin
        regulator_source_control_reg <= BUS_REQ.wdata;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_RDATA  <= 16'h0000;
      BUS_RVALID <= 1'b0;
    end else begin
      BUS_RVALID <= BUS_REQ.re;
      if (BUS_REQ.re) begin
        unique case (BUS_REQ.addr)
          psr_pkg::TARGET_WORD_OFS: BUS_RDATA <= target_value_word_reg;
          psr_pkg::SRC_CTRL_OFS:    BUS_RDATA <= regulator_source_control_reg;
          default:                  BUS_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================
  // Analog input synchronisers, three stages each
  logic [15:0] ain1_s1, ain1_s2, ain1_s3, ain1_val;
  logic [15:0] ain2_s1, ain2_s2, ain2_s3, ain2_val;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ain1_s1 <= 16'h0000; ain1_s2 <= 16'h0000; ain1_s3 <= 16'h0000;
      ain2_s1 <= 16'h0000; ain2_s2 <= 16'h0000; ain2_s3 <= 16'h0000;
      ain1_val <= 16'h0000;
      ain2_val <= 16'h0000;
    end else begin
      ain1_s1 <= ANALOG_IN1; ain1_s2 <= ain1_s1; ain1_s3 <= ain1_s2;
      ain2_s1 <= ANALOG_IN2; ain2_s2 <= ain2_s1; ain2_s3 <= ain2_s2;
      // Accept a new word only once two stages agree, so skew is never sampled
      if (ain1_s2 == ain1_s3) begin
        ain1_val <= ain1_s3;
      end
      if (ain2_s2 == ain2_s3) begin
        ain2_val <= ain2_s3;
      end
    end
  end

  // ==========================================
  // Source selection and configuration faults
  logic        tgt_from_ain1, tgt_from_ain2, fb_from_ain1, fb_from_ain2;
  logic [15:0] target_sel;
  logic [15:0] feedback_sel;

  always_comb begin
    tgt_from_ain1 = (CFG.ain1_fn == psr_pkg::AIN_FN_TARGET);   // R15
    tgt_from_ain2 = (CFG.ain2_fn == psr_pkg::AIN_FN_TARGET);
    fb_from_ain1  = (CFG.ain1_fn == psr_pkg::AIN_FN_FEEDBACK); // R17
    fb_from_ain2  = (CFG.ain2_fn == psr_pkg::AIN_FN_FEEDBACK);
    if (tgt_from_ain1) begin                                   // R14
      target_sel = ain1_val;
    end else if (tgt_from_ain2) begin
      target_sel = ain2_val;
    end else if (CFG.param_tgt_en) begin
      target_sel = CFG.param_tgt;
    end else if (regulator_source_control_reg[psr_pkg::SRC_TARGET_BIT]) begin
      target_sel = target_value_word_reg;
    end else begin
      target_sel = 16'h0000;
    end
    if (CFG.diff_fb_en) begin                                  // R19
      feedback_sel = ain1_val - ain2_val;
    end else if (fb_from_ain1) begin
      feedback_sel = ain1_val;
    end else if (fb_from_ain2) begin
      feedback_sel = ain2_val;
    end else begin
      feedback_sel = 16'h0000;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DUP_TARGET_FAULT   <= 1'b0;
      DUP_FEEDBACK_FAULT <= 1'b0;
    end else begin
      // Faults track the settings and clear as soon as the conflict is gone
      DUP_TARGET_FAULT   <= tgt_from_ain1 && tgt_from_ain2;                  // R16
      DUP_FEEDBACK_FAULT <= (fb_from_ain1 && fb_from_ain2) ||
                            (CFG.diff_fb_en && (fb_from_ain1 || fb_from_ain2)); // R18
    end
  end

  // ==========================================
  // Sample tick divider
  // One tick paces the whole chain; a faster tick gives finer timing but wider sums
  logic [psr_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic                           tick;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_reg <= '0;
      tick         <= 1'b0;
    end else if (tick_cnt_reg == psr_pkg::TICK_CNT_W'(psr_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick         <= 1'b1; // R21
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick         <= 1'b0;
    end
  end

  // ==========================================
  // Chain arithmetic, all in signed ACC_W with FRAC_W fraction
  function automatic logic signed [AW-1:0] pct_of_max(input logic signed [16:0] pct);
    logic signed [AW-1:0] full;
    full = AW'($signed({1'b0, MAX_OUTPUT_FREQUENCY})) <<< FW;
    pct_of_max = AW'((full * AW'(pct)) / AW'(psr_pkg::PCT_MAX));
  endfunction

  function automatic logic signed [AW-1:0] clamp(input logic signed [AW-1:0] v,
                                                 input logic signed [AW-1:0] lim);
    if (v > lim) begin
      clamp = lim;
    end else if (v < -lim) begin
      clamp = -lim;
    end else begin
      clamp = v;
    end
  endfunction

  // Mode decode shared by the enable, derivative source and command adder
  function automatic logic mode_is(input logic [2:0] m, input psr_pkg::psr_mode_t code);
    mode_is = (m == 3'(code));
  endfunction

  // ==========================================
  // Setting range limits
  // Out-of-range settings other than the mode sit at the nearest end of their range
  // instead of being refused; a mode above 4 turns the loop off as mode 0 does
  function automatic logic [15:0] cap(input logic [15:0] v, input logic [15:0] top);
    cap = (v > top) ? top : v;
  endfunction

  function automatic logic signed [15:0] cap_signed(input logic signed [15:0] v,
                                                    input logic signed [15:0] top);
    if (v > top) begin
      cap_signed = top;
    end else if (v < -top) begin
      cap_signed = -top;
    end else begin
      cap_signed = v;
    end
  endfunction

  logic        [15:0] p_gain_lim, i_time_lim, i_clamp_lim, d_time_lim;
  logic        [15:0] out_limit_lim, lag_time_lim, out_gain_lim;
  logic signed [15:0] bias_lim;

  always_comb begin
    p_gain_lim    = cap(CFG.p_gain, psr_pkg::GAIN_MAX);                        // R05
    i_time_lim    = cap(CFG.i_time, psr_pkg::ITIME_MAX);                       // R06
    i_clamp_lim   = cap(CFG.i_clamp, psr_pkg::PCT_MAX);                        // R07
    d_time_lim    = cap(CFG.d_time, psr_pkg::DTIME_MAX);                       // R08
    out_limit_lim = cap(CFG.out_limit, psr_pkg::PCT_MAX);                      // R09
    bias_lim      = cap_signed($signed(CFG.bias), $signed(psr_pkg::PCT_MAX));  // R10
    lag_time_lim  = cap(CFG.lag_time, psr_pkg::LAG_MAX);                       // R11
    out_gain_lim  = cap(CFG.out_gain, psr_pkg::GAIN_MAX);                      // R13
  end

  // ==========================================
  // Regulator chain
  logic                 enabled, d_on_fb, add_cmd;
  logic signed [AW-1:0] dev, fb_ext, p_term, integ_reg, integ_next, i_lim;
  logic signed [AW-1:0] d_src, d_prev_reg, d_term, sum, lag_reg, lag_next;
  logic signed [AW-1:0] gained, signed_out, final_out, limit_pct, cmd_ext;
  logic [31:0]          i_ticks, d_ticks, lag_ticks;

  assign enabled = !mode_is(CFG.mode, psr_pkg::MODE_OFF) &&
                   (CFG.mode <= psr_pkg::MODE_MAX);                 // R01
  assign d_on_fb = mode_is(CFG.mode, psr_pkg::MODE_DIRECT_FB) ||
                   mode_is(CFG.mode, psr_pkg::MODE_ADD_FB);         // R03
  assign add_cmd = mode_is(CFG.mode, psr_pkg::MODE_ADD_DEV) ||
                   mode_is(CFG.mode, psr_pkg::MODE_ADD_FB);         // R04

  assign dev    = (AW'($signed(target_sel)) - AW'($signed(feedback_sel))) <<< FW; // R02
  assign fb_ext = AW'($signed(feedback_sel)) <<< FW;
  assign cmd_ext = AW'(FREQ_COMMAND) <<< FW;

  psr_scale u_pgain (
    .value  (dev),
    .gain   (p_gain_lim),
    .result (p_term)
  ); // R05

  // The integral advances only on the tick, so its rate follows the integral time
  always_comb begin
    i_ticks    = 32'(i_time_lim) * 32'(TICKS_PER_DECI);
    i_lim      = pct_of_max(17'($signed({1'b0, i_clamp_lim})));
    if (i_time_lim == 16'h0000) begin
      integ_next = '0;                                                  // R06
    end else begin
      integ_next = clamp(integ_reg + p_term / AW'($signed({1'b0, i_ticks})), i_lim); // R07
    end
  end

  always_comb begin
    d_ticks = 32'(d_time_lim) * 32'(TICKS_PER_DECI / 10);
    d_src   = d_on_fb ? -fb_ext : p_term;                               // R03
    if (d_time_lim == 16'h0000) begin
      d_term = '0;                                                      // R08
    end else begin
      d_term = (d_src - d_prev_reg) * AW'($signed({1'b0, d_ticks}));
    end
    sum = p_term + integ_next + d_term +
          pct_of_max(17'(bias_lim));                                    // R10
    lag_ticks = 32'(lag_time_lim) * 32'(TICKS_PER_DECI / 10);
    if (lag_time_lim == 16'h0000) begin
      lag_next = sum;
    end else begin
      lag_next = lag_reg + (sum - lag_reg) / AW'($signed({1'b0, lag_ticks}) + 1); // R11
    end
    signed_out = CFG.sign_invert ? -lag_next : lag_next;               // R12
  end

  psr_scale u_ogain (
    .value  (signed_out),
    .gain   (out_gain_lim),
    .result (gained)
  ); // R13

  always_comb begin
    limit_pct = pct_of_max(17'($signed({1'b0, out_limit_lim})));
    final_out = clamp(gained, limit_pct);                               // R09
    if (add_cmd) begin
      final_out = final_out + cmd_ext;                                  // R04
    end else if (!CFG.reverse_en && final_out < 0) begin
      final_out = '0;                                                   // R20
    end
  end

  // ==========================================
  // Tick-registered state and outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      integ_reg  <= '0;
      d_prev_reg <= '0;
      lag_reg    <= '0;
    end else if (tick && enabled) begin                                 // R21
      integ_reg  <= integ_next;
      d_prev_reg <= d_src;
      lag_reg    <= lag_next;
    // History is cleared while off so enabling the loop starts without a bump
    end else if (!enabled) begin
      integ_reg  <= '0;
      d_prev_reg <= '0;
      lag_reg    <= '0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      OUTPUT_FREQUENCY  <= 16'sh0000;
      REVERSE_RUN       <= 1'b0;
      DEVIATION_MONITOR <= 16'sh0000;
      FEEDBACK_MONITOR  <= 16'sh0000;
    end else if (tick) begin
      // Monitors refresh on every tick, even with the regulator off
      DEVIATION_MONITOR <= 16'(dev >>> FW);
      FEEDBACK_MONITOR  <= $signed(feedback_sel);
      if (enabled) begin
        OUTPUT_FREQUENCY <= 16'(final_out >>> FW);
        REVERSE_RUN      <= final_out < 0;                              // R20
      end else begin
        OUTPUT_FREQUENCY <= FREQ_COMMAND;                               // R01
        REVERSE_RUN      <= 1'b0;
      end
    end
  end
endmodule

// File: verification/psr_sensor_model.sv
`timescale 1ns/1ps
// ==========================================
// Analog sensor pair feeding the two input terminals
module psr_sensor_model (
  // Requested sensor levels
  input  wire logic [15:0] level_a,
  input  wire logic [15:0] level_b,
  // Terminal levels, lagging like a real sensor so nothing lands on a clock edge
  output logic      [15:0] ain1,
  output logic      [15:0] ain2
);
  assign #3 ain1 = level_a;
  assign #3 ain2 = level_b;
endmodule

// File: verification/psr_regulator_checker.sv
`timescale 1ns/1ps
// ==========================================
// Bus, fault and tick checker
module psr_regulator_checker (
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  RST_N,
  // Stimulus
  input wire psr_pkg::psr_cfg_t     CFG,
  input wire logic signed [15:0]    FREQ_COMMAND,
  input wire psr_pkg::psr_bus_req_t BUS_REQ,
  // Results
  input wire logic [15:0]           BUS_RDATA,
  input wire logic                  BUS_RVALID,
  input wire logic signed [15:0]    OUTPUT_FREQUENCY,
  input wire logic                  DUP_TARGET_FAULT,
  input wire logic                  DUP_FEEDBACK_FAULT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  int gap_reg;
  // Saturates so a long quiet output cannot wrap the count
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_reg <= 0;
    end else if ($changed(OUTPUT_FREQUENCY)) begin
      gap_reg <= 0;
    end else if (gap_reg < psr_pkg::TICK_CYCLES) begin
      gap_reg <= gap_reg + 1;
    end
  end
  a_read_answered: assert property (BUS_REQ.re |=> BUS_RVALID)
    else $error("read not answered next cycle");
  a_answer_unasked: assert property (!BUS_REQ.re |=> !BUS_RVALID)
    else $error("answer without a read");
  a_unmapped_zero: assert property (BUS_REQ.re && BUS_REQ.addr != psr_pkg::TARGET_WORD_OFS
      && BUS_REQ.addr != psr_pkg::SRC_CTRL_OFS |=> BUS_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_target_readback: assert property (BUS_REQ.re && BUS_REQ.addr == psr_pkg::TARGET_WORD_OFS
      && $past(BUS_REQ.we) && $past(BUS_REQ.addr) == psr_pkg::TARGET_WORD_OFS
      |=> BUS_RDATA == $past(BUS_REQ.wdata, 2))
    else $error("target word not read back");
  a_target_dup_set: assert property ((CFG.ain1_fn == psr_pkg::AIN_FN_TARGET
      && CFG.ain2_fn == psr_pkg::AIN_FN_TARGET) [*2] |-> DUP_TARGET_FAULT)
    else $error("duplicate target not flagged");
  a_target_dup_clear: assert property ((CFG.ain1_fn != psr_pkg::AIN_FN_TARGET
      || CFG.ain2_fn != psr_pkg::AIN_FN_TARGET) [*2] |-> !DUP_TARGET_FAULT)
    else $error("target fault without cause");
  a_feedback_dup_set: assert property ((CFG.diff_fb_en
      && CFG.ain1_fn == psr_pkg::AIN_FN_FEEDBACK) [*2] |-> DUP_FEEDBACK_FAULT)
    else $error("duplicate feedback not flagged");
  a_feedback_dup_clear: assert property ((!CFG.diff_fb_en
      && CFG.ain1_fn != psr_pkg::AIN_FN_FEEDBACK && CFG.ain2_fn != psr_pkg::AIN_FN_FEEDBACK)
      [*2] |-> !DUP_FEEDBACK_FAULT)
    else $error("feedback fault without cause");
  a_output_on_tick: assert property ($changed(OUTPUT_FREQUENCY)
      |-> gap_reg >= psr_pkg::TICK_CYCLES - 2)
    else $error("output moved between ticks");
  a_off_passes_cmd: assert property ($changed(OUTPUT_FREQUENCY) && CFG.mode == 3'h0
      && $stable(FREQ_COMMAND) |-> OUTPUT_FREQUENCY == FREQ_COMMAND)
    else $error("disabled mode output not the command");
  c_read: cover property (BUS_REQ.re ##1 BUS_RVALID);
  c_target_fault: cover property ($rose(DUP_TARGET_FAULT));
  c_output_tick: cover property ($changed(OUTPUT_FREQUENCY));
endmodule

bind psr_regulator psr_regulator_checker u_checker (
  .CLK(CLK),
  .RST_N(RST_N),
  .CFG(CFG),
  .FREQ_COMMAND(FREQ_COMMAND),
  .BUS_REQ(BUS_REQ),
  .BUS_RDATA(BUS_RDATA),
  .BUS_RVALID(BUS_RVALID),
  .OUTPUT_FREQUENCY(OUTPUT_FREQUENCY),
  .DUP_TARGET_FAULT(DUP_TARGET_FAULT),
  .DUP_FEEDBACK_FAULT(DUP_FEEDBACK_FAULT)
);

// File: verification/pid_speed_regulator_tb_top.sv
`timescale 1ns/1ps
module pid_speed_regulator_tb_top;
  logic                  CLK = 1'b0;
  logic                  RST_N = 1'b0;
  psr_pkg::psr_cfg_t     cfg;
  psr_pkg::psr_bus_req_t bus_req = '0;
  logic signed [15:0]    fcmd = 16'sh0000;
  logic        [15:0]    lvl_a = 16'h0800;
  logic        [15:0]    lvl_b = 16'h0400;
  logic        [15:0]    ain1;
  logic        [15:0]    ain2;
  logic        [15:0]    rdata;
  logic                  rvalid;
  logic signed [15:0]    out_freq;
  logic                  tgt_fault;
  logic                  fb_fault;
  logic                  rev_run;
  logic signed [15:0]    dev_mon;
  logic signed [15:0]    fb_mon;
  logic        [15:0]    max_freq = 16'h1770;
  int                    failures = 0;
  int                    samples_checked = 0;
  // Fault table: terminal 1 code, terminal 2 code, difference mode, expected faults
  logic        [3:0]     fn1_tab [5] = '{4'h9, 4'h9, 4'h8, 4'h8, 4'h0};
  logic        [3:0]     fn2_tab [5] = '{4'h9, 4'h0, 4'h0, 4'h0, 4'h9};
  logic                  dif_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic                  tgt_tab [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic                  fbf_tab [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  always #4 CLK = ~CLK;

  psr_sensor_model u_sensor (
    .level_a(lvl_a),
    .level_b(lvl_b),
    .ain1(ain1),
    .ain2(ain2)
  );

  psr_regulator uut (
    .CLK(CLK),
    .RST_N(RST_N),
    .CFG(cfg),
    .MAX_OUTPUT_FREQUENCY(max_freq),
    .ANALOG_IN1(ain1),
    .ANALOG_IN2(ain2),
    .FREQ_COMMAND(fcmd),
    .BUS_REQ(bus_req),
    .BUS_RDATA(rdata),
    .BUS_RVALID(rvalid),
    .OUTPUT_FREQUENCY(out_freq),
    .REVERSE_RUN(rev_run),
    .DEVIATION_MONITOR(dev_mon),
    .FEEDBACK_MONITOR(fb_mon),
    .DUP_TARGET_FAULT(tgt_fault),
    .DUP_FEEDBACK_FAULT(fb_fault)
  );

  // ==========================================
  // Shared tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One full tick period plus the output register, so a tick has used the new settings
  task automatic settle_tick;
    repeat (psr_pkg::TICK_CYCLES + 2) @(posedge CLK);
    #1;
  endtask

  // Write is held for exactly one taking edge; the next call replaces it
  task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK);
    #1 bus_req = {1'b1, 1'b0, a, d};
  endtask

  task automatic bus_read(input logic [15:0] a, input logic [15:0] exp);
    @(posedge CLK);
    #1 bus_req = {1'b0, 1'b1, a, 16'h0000};
    @(posedge CLK);
    #1 bus_req = '0;
    compare("answer strobe", 16'h0001, {15'h0000, rvalid});
    compare("read word", exp, rdata);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    cfg = '0;
    cfg.p_gain = psr_pkg::GAIN_DEFAULT;
    cfg.i_time = psr_pkg::ITIME_DEFAULT;
    cfg.i_clamp = psr_pkg::PCT_MAX;
    cfg.out_limit = psr_pkg::PCT_MAX;
    cfg.out_gain = psr_pkg::GAIN_DEFAULT;
    repeat (20) @(posedge CLK);
    #1 RST_N = 1'b1;
    bus_write(psr_pkg::TARGET_WORD_OFS, 16'h1A5C);
    bus_read(psr_pkg::TARGET_WORD_OFS, 16'h1A5C);
    bus_write(psr_pkg::SRC_CTRL_OFS, 16'h0002);
    bus_read(psr_pkg::SRC_CTRL_OFS, 16'h0002);
    bus_write(16'h0007, 16'hFFFF);
    bus_read(16'h0007, 16'h0000);
    bus_read(psr_pkg::TARGET_WORD_OFS, 16'h1A5C);
    bus_write(psr_pkg::TARGET_WORD_OFS, 16'hE3F1);
    bus_read(psr_pkg::TARGET_WORD_OFS, 16'hE3F1);
    for (int k = 0; k < 5; k++) begin
      @(posedge CLK);
      #1 cfg.ain1_fn = fn1_tab[k];
      cfg.ain2_fn = fn2_tab[k];
      cfg.diff_fb_en = dif_tab[k];
      repeat (2) @(posedge CLK);
      #1 compare("target fault", {15'h0000, tgt_tab[k]}, {15'h0000, tgt_fault});
      compare("feedback fault", {15'h0000, fbf_tab[k]}, {15'h0000, fb_fault});
    end
    // Disabled regulator must hand the command straight through at the next tick
    cfg.mode = 3'h0;
    fcmd = 16'sh0123;
    for (int i = 0; i < psr_pkg::TICK_CYCLES + 20 && out_freq === 16'sh0000; i++) begin
      @(posedge CLK);
      #1;
    end
    compare("output frequency", 16'h0123, out_freq);
    // Mode 1: parameter target 0A00 against terminal 1 feedback 0800, P only
    cfg.mode = 3'h1;
    cfg.i_time = 16'h0000;
    cfg.ain1_fn = psr_pkg::AIN_FN_FEEDBACK;
    cfg.ain2_fn = 4'h0;
    cfg.param_tgt_en = 1'b1;
    cfg.param_tgt = 16'h0A00;
    settle_tick;
    compare("output frequency", 16'h0200, out_freq);
    compare("deviation monitor", 16'h0200, dev_mon);
    compare("feedback monitor", 16'h0800, fb_mon);
    compare("reverse run", 16'h0000, {15'h0000, rev_run});
    cfg.sign_invert = 1'b1;
    settle_tick;
    compare("output frequency", 16'h0000, out_freq);
    cfg.reverse_en = 1'b1;
    settle_tick;
    compare("output frequency", 16'hFE00, out_freq);
    compare("reverse run", 16'h0001, {15'h0000, rev_run});
    // Mode 3: 5.0% of 6000 caps the regulator at 300, then the command adds on
    cfg.mode = 3'h3;
    cfg.sign_invert = 1'b0;
    cfg.out_limit = 16'h0032;
    settle_tick;
    compare("output frequency", 16'h024F, out_freq);
    test_done;
  end

  // ==========================================
  // Watchdog: five tick waits plus margin for the bus and fault phases
  initial begin
    repeat (psr_pkg::TICK_CYCLES * 6 + 5000) @(posedge CLK);
    failures++;
    test_done;
  end
endmodule
